/* rtl/ecm_pkg.sv */
/*
 * Shared constants and carriers for the external and comparator
 * interrupt front end. Assumes one 200 MHz clock and a byte-wide
 * register port driven by the CPU core.
 */
package ecm_pkg;
	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [19:0] ADDR_PIN_RISE = 20'hF0518;
	localparam logic [19:0] ADDR_PIN_FALL = 20'hF0519;
	localparam logic [19:0] ADDR_CMP_RISE = 20'hF0558;
	localparam logic [19:0] ADDR_CMP_FALL = 20'hF0559;
	localparam logic [19:0] ADDR_MONITOR = 20'hF05C3;
	localparam logic [19:0] ADDR_MASK = 20'hF05C0;
	localparam logic [19:0] ADDR_PSW = 20'hFFFFA;
	// ------------------------------------------------------------
	// Reset values and field layout
	// ------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_MASK = 8'hFF;
	localparam logic [7:0] RST_PSW = 8'h06;
	localparam logic [2:0] PSW_IE_BIT = 3'h7;
	localparam int PSW_ISP_LO = 1;
	localparam int PSW_ISP_HI = 2;
	localparam logic [1:0] PRIO_TOP = 2'h0;
	localparam logic [1:0] PRIO_STEP = 2'h1;
	localparam int N_PIN = 4;
	localparam int N_CMP = 6;
	localparam int N_CMP_MASKED = 3;
	localparam int CMP_MASK_FIRST = 3;
	localparam int MASK_CMP_POS = 4;
	localparam int TRS_A_POS = 6;
	localparam int TRS_B_POS = 7;
	localparam logic MASK_TOP_READ = 1'h1;
	localparam logic [3:0] MON_UPPER_READ = 4'h0;
	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic bit_op;
		logic [19:0] addr;
		logic [2:0] bit_idx;
		logic bit_val;
		logic [7:0] wdata;
	} ecm_bus_req_t;
	typedef struct packed {
		logic ack_maskable;
		logic [1:0] ack_priority;
		logic software_break_instruction;
		logic ei;
		logic di;
		logic push;
		logic restore;
		logic [7:0] restore_data;
	} ecm_cpu_evt_t;
endpackage

/* rtl/ecm_irq_front.sv */
/*
 * Edge selection, request masking, monitor flags, timer restart and
 * the status word of the external/comparator interrupt front end.
 * Read data follows a taken read by one clock and holds until the
 * next read. A pin or comparator change shows as a one-clock request
 * two clocks after it is sampled. Priority choice and vectoring
 * live in the CPU core; only the status word side of an acknowledge
 * is kept here.
 * Assumes pins and comparator outputs are asynchronous, while the
 * invert selects, the register port and CPU events share the clock.
 */
// Functional notes
// - Pin edge pair 00 disables detection, 01 falling, 10 rising.
// - Pin edge pair 11 detects both rising and falling edges.
// - Comparator edge pair 7 selects edge of timer-linked pin B.
// - Comparator edge pair 6 selects edge of timer-linked pin A.
// - Timer restart stays low while its comparator edge pair is disabled.
// - Comparator edge pairs 0 to 5 select comparator request edges.
// - Comparator edge applies after the optional detect inversion.
// - Mask bits 0-3 gate pins, 4-6 comparators 3-5; bit 7 reads 1.
// - Mask register resets to all ones.
// - Pin request sets its monitor flag, cleared only by software.
// - While monitor flag is set, further pin requests are ignored.
// - Monitor supports bit read/write and byte read; byte writes ignored.
// - Monitor flags sit in bits 3..0; upper four bits read zero.
// - Status word has byte, bit and enable/disable instruction access.
// - Vectored acknowledge or break pushes status and clears enable.
// - Maskable acknowledge with nonzero priority loads priority minus one.
// - Push instruction saves status; returns and pop restore it.
// - Status word resets to 06 hex.
// - Maskable acknowledge is taken only while the enable flag is set.
`timescale 1ns/100ps
`default_nettype none
module ecm_irq_front
	import ecm_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [N_PIN-1:0] ext_pin,
	input wire logic [N_CMP-1:0] cmp_detect,
	input wire logic [N_CMP-1:0] comparator_invert_select,
	input wire ecm_bus_req_t bus_req,
	input wire ecm_cpu_evt_t cpu_evt,
	output logic [7:0] bus_rdata_ff,
	output logic [N_PIN-1:0] external_pin_request_ff,
	output logic [N_CMP-1:0] comparator_detect_request_ff,
	output logic timer_restart_a_ff,
	output logic timer_restart_b_ff,
	output logic [7:0] psw_ff,
	output logic [7:0] psw_push_data_ff,
	output logic psw_push_stb_ff
);
	// ------------------------------------------------------------
	// Edge and write-merge helpers
	// ------------------------------------------------------------
	function automatic logic edge_hit(input logic prev, input logic cur,
		input logic rise, input logic fall);
		edge_hit = (rise & ~prev & cur) | (fall & prev & ~cur);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old,
		input ecm_bus_req_t r);
		logic [7:0] m;
		m = old;
		m[r.bit_idx] = r.bit_val;
		merge = r.bit_op ? m : r.wdata;
	endfunction

	// ------------------------------------------------------------
	// Input synchronisers and previous samples
	// ------------------------------------------------------------
	logic [N_PIN-1:0] pin_s1_ff, pin_s2_ff, pin_prev_ff;
	logic [N_CMP-1:0] cmp_s1_ff, cmp_s2_ff, cmp_prev_ff;
	logic [N_CMP-1:0] cmp_inv;

	// The first stage feeds only the second stage.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			pin_prev_ff <= '0;
			cmp_s1_ff <= '0;
			cmp_s2_ff <= '0;
			cmp_prev_ff <= '0;
		end else begin
			pin_s1_ff <= ext_pin;
			pin_s2_ff <= pin_s1_ff;
			pin_prev_ff <= pin_s2_ff;
			cmp_s1_ff <= cmp_detect;
			cmp_s2_ff <= cmp_s1_ff;
			cmp_prev_ff <= cmp_inv;
		end
	end

	// Edges are judged on the inverted signal, so changing an invert
	// select can itself look like an edge; software should expect it.
	assign cmp_inv = cmp_s2_ff ^ comparator_invert_select;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	logic [7:0] pin_rise_edge_enable_ff, pin_fall_edge_enable_ff;
	logic [7:0] cmp_rise_edge_bit_ff, cmp_fall_edge_bit_ff;
	logic [N_PIN-1:0] request_monitor_bit_ff;
	logic [6:0] request_mask_bit_ff;
	logic wr, rd, sel_pr, sel_pf, sel_cr, sel_cf, sel_mon, sel_mk, sel_psw;
	logic wr_pr, wr_pf, wr_cr, wr_cf, wr_mk, wr_psw;
	logic mon_bit_wr;
	logic [7:0] mask_view, mon_view, mask_wr, rd_mux;

	assign wr = bus_req.valid & bus_req.write;
	assign rd = bus_req.valid & ~bus_req.write;
	assign sel_pr = bus_req.addr == ADDR_PIN_RISE;
	assign sel_pf = bus_req.addr == ADDR_PIN_FALL;
	assign sel_cr = bus_req.addr == ADDR_CMP_RISE;
	assign sel_cf = bus_req.addr == ADDR_CMP_FALL;
	assign sel_mon = bus_req.addr == ADDR_MONITOR;
	assign sel_mk = bus_req.addr == ADDR_MASK;
	assign sel_psw = bus_req.addr == ADDR_PSW;

	// ------------------------------------------------------------
	// Write strobes
	// ------------------------------------------------------------
	// Byte writes to the monitor are dropped; only bit writes land.
	assign mon_bit_wr = wr & sel_mon & bus_req.bit_op;
	assign wr_pr = wr & sel_pr;
	assign wr_pf = wr & sel_pf;
	assign wr_cr = wr & sel_cr;
	assign wr_cf = wr & sel_cf;
	assign wr_mk = wr & sel_mk;
	assign wr_psw = wr & sel_psw;

	// ------------------------------------------------------------
	// Read views
	// ------------------------------------------------------------
	assign mask_view = {MASK_TOP_READ, request_mask_bit_ff};
	// Bit 7 of the mask is fixed, so a write merges into the read view
	// and only the seven real bits are kept.
	assign mask_wr = merge(mask_view, bus_req);
	assign mon_view = {MON_UPPER_READ, request_monitor_bit_ff};
	// Unmapped reads return zero rather than a stale value.
	assign rd_mux = sel_pr ? pin_rise_edge_enable_ff :
		sel_pf ? pin_fall_edge_enable_ff :
		sel_cr ? cmp_rise_edge_bit_ff :
		sel_cf ? cmp_fall_edge_bit_ff :
		sel_mon ? mon_view :
		sel_mk ? mask_view :
		sel_psw ? psw_ff : RST_ZERO;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pin_rise_edge_enable_ff <= RST_ZERO;
			pin_fall_edge_enable_ff <= RST_ZERO;
			cmp_rise_edge_bit_ff <= RST_ZERO;
			cmp_fall_edge_bit_ff <= RST_ZERO;
			request_mask_bit_ff <= RST_MASK[6:0];
		end else begin
			if (wr_pr)
				pin_rise_edge_enable_ff <= merge(pin_rise_edge_enable_ff, bus_req);
			if (wr_pf)
				pin_fall_edge_enable_ff <= merge(pin_fall_edge_enable_ff, bus_req);
			if (wr_cr)
				cmp_rise_edge_bit_ff <= merge(cmp_rise_edge_bit_ff, bus_req);
			if (wr_cf)
				cmp_fall_edge_bit_ff <= merge(cmp_fall_edge_bit_ff, bus_req);
			if (wr_mk)
				request_mask_bit_ff <= mask_wr[6:0];
		end
	end

	// Read data holds between reads, so a slow reader still sees it.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			bus_rdata_ff <= RST_ZERO;
		end else if (rd) begin
			bus_rdata_ff <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// Pin requests and monitor flags
	// ------------------------------------------------------------
	logic [N_PIN-1:0] pin_edge, pin_gen, nxt_monitor, pin_out;

	genvar gi;
	generate
		for (gi = 0; gi < N_PIN; gi++) begin : g_pin
			assign pin_edge[gi] = edge_hit(pin_prev_ff[gi], pin_s2_ff[gi],
				pin_rise_edge_enable_ff[gi], pin_fall_edge_enable_ff[gi]);
			// A set flag shuts the pin out until software clears it.
			assign pin_gen[gi] = pin_edge[gi] & ~request_monitor_bit_ff[gi];
			// A new request wins over a clear in the same cycle.
			assign nxt_monitor[gi] = pin_gen[gi] |
				((mon_bit_wr && bus_req.bit_idx == gi) ?
				bus_req.bit_val : request_monitor_bit_ff[gi]);
			assign pin_out[gi] = pin_gen[gi] & ~request_mask_bit_ff[gi];
		end
	endgenerate

	// ------------------------------------------------------------
	// Comparator requests and timer restart
	// ------------------------------------------------------------
	logic [N_CMP-1:0] cmp_edge, cmp_out;
	logic trs_a, trs_b;

	generate
		for (gi = 0; gi < N_CMP; gi++) begin : g_cmp
			assign cmp_edge[gi] = edge_hit(cmp_prev_ff[gi], cmp_inv[gi],
				cmp_rise_edge_bit_ff[gi], cmp_fall_edge_bit_ff[gi]);
			if (gi >= CMP_MASK_FIRST) begin : g_mk
				assign cmp_out[gi] = cmp_edge[gi] &
					~request_mask_bit_ff[gi - CMP_MASK_FIRST + MASK_CMP_POS];
			end else begin : g_nomk
				assign cmp_out[gi] = cmp_edge[gi];
			end
		end
	endgenerate

	// With both bits clear edge_hit is zero, so the restart holds low.
	assign trs_a = edge_hit(pin_prev_ff[0], pin_s2_ff[0],
		cmp_rise_edge_bit_ff[TRS_A_POS], cmp_fall_edge_bit_ff[TRS_A_POS]);
	assign trs_b = edge_hit(pin_prev_ff[1], pin_s2_ff[1],
		cmp_rise_edge_bit_ff[TRS_B_POS], cmp_fall_edge_bit_ff[TRS_B_POS]);

	// Monitor flags are state and the pulses are not, so they sit apart.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			request_monitor_bit_ff <= RST_ZERO[N_PIN-1:0];
		end else begin
			request_monitor_bit_ff <= nxt_monitor;
		end
	end

	// The restart pulses ignore mask and monitor; the timer wants them all.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			external_pin_request_ff <= '0;
			comparator_detect_request_ff <= '0;
			timer_restart_a_ff <= 1'b0;
			timer_restart_b_ff <= 1'b0;
		end else begin
			external_pin_request_ff <= pin_out;
			comparator_detect_request_ff <= cmp_out;
			timer_restart_a_ff <= trs_a;
			timer_restart_b_ff <= trs_b;
		end
	end

	// ------------------------------------------------------------
	// Status word
	// ------------------------------------------------------------
	logic ack_taken, vec_entry, save_psw;
	logic [1:0] isp_load;
	logic [7:0] psw_entry, psw_instr, nxt_psw;

	// A maskable acknowledge is void while maskable requests are off.
	assign ack_taken = cpu_evt.ack_maskable & psw_ff[PSW_IE_BIT];
	assign vec_entry = ack_taken | cpu_evt.software_break_instruction;
	assign save_psw = vec_entry | cpu_evt.push;
	assign isp_load = (cpu_evt.ack_priority != PRIO_TOP) ?
		cpu_evt.ack_priority - PRIO_STEP : psw_ff[PSW_ISP_HI:PSW_ISP_LO];

	always_comb begin
		psw_entry = psw_ff;
		psw_entry[PSW_IE_BIT] = 1'b0;
		if (ack_taken)
			psw_entry[PSW_ISP_HI:PSW_ISP_LO] = isp_load;
		psw_instr = (wr && sel_psw) ? merge(psw_ff, bus_req) : psw_ff;
		if (cpu_evt.ei)
			psw_instr[PSW_IE_BIT] = 1'b1;
		if (cpu_evt.di)
			psw_instr[PSW_IE_BIT] = 1'b0;
		// Restore outranks entry, which outranks plain instructions.
		nxt_psw = cpu_evt.restore ? cpu_evt.restore_data :
			vec_entry ? psw_entry : psw_instr;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			psw_ff <= RST_PSW;
			psw_push_stb_ff <= 1'b0;
		end else begin
			psw_ff <= nxt_psw;
			psw_push_stb_ff <= save_psw;
		end
	end

	// The copy taken is the word before this cycle's update, which is
	// what the stack must receive on entry.
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			psw_push_data_ff <= RST_ZERO;
		end else if (save_psw) begin
			psw_push_data_ff <= psw_ff;
		end
	end
endmodule // ecm_irq_front
`default_nettype wire

/* sim/ecm_irq_front_properties.sv */
/*
 * Port checker for ecm_irq_front: status word and register reads.
 * Assumes it is bound to the design and sees one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module ecm_props
	import ecm_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire ecm_bus_req_t bus_req,
	input wire ecm_cpu_evt_t cpu_evt,
	input wire logic [7:0] bus_rdata_ff,
	input wire logic [N_PIN-1:0] external_pin_request_ff,
	input wire logic [7:0] psw_ff,
	input wire logic [7:0] psw_push_data_ff,
	input wire logic psw_push_stb_ff
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	// A restore outranks the other status updates; a bus write is excluded too.
	wire logic quiet = !cpu_evt.restore && !(bus_req.valid && bus_req.write);
	wire logic rd_mon = bus_req.valid && !bus_req.write
		&& bus_req.addr == ADDR_MONITOR;
	property p_brk;
		cpu_evt.software_break_instruction && !cpu_evt.restore |=> psw_push_stb_ff && !psw_ff[7];
	endproperty
	a_brk: assert property (p_brk) else $error("break push bad");
	property p_push;
		cpu_evt.push && !cpu_evt.restore
		|=> psw_push_stb_ff && psw_push_data_ff == $past(psw_ff);
	endproperty
	a_push: assert property (p_push) else $error("push data bad");
	property p_isp;
		cpu_evt.ack_maskable && psw_ff[7] && cpu_evt.ack_priority != 2'h0
		&& quiet |=> psw_ff[2:1] == $past(cpu_evt.ack_priority) - 2'h1;
	endproperty
	a_isp: assert property (p_isp) else $error("priority load bad");
	property p_ack_off;
		cpu_evt.ack_maskable && !psw_ff[7] && !cpu_evt.software_break_instruction && !cpu_evt.ei
		&& !cpu_evt.push && quiet |=> !psw_push_stb_ff && $stable(psw_ff);
	endproperty
	a_ack_off: assert property (p_ack_off) else $error("ack taken");
	property p_rest;
		cpu_evt.restore |=> psw_ff == $past(cpu_evt.restore_data);
	endproperty
	a_rest: assert property (p_rest) else $error("restore bad");
	property p_di;
		cpu_evt.di && quiet && !cpu_evt.ack_maskable |=> !psw_ff[7];
	endproperty
	a_di: assert property (p_di) else $error("disable bad");
	property p_mon;
		rd_mon |=> bus_rdata_ff[7:4] == MON_UPPER_READ;
	endproperty
	a_mon: assert property (p_mon) else $error("monitor top bad");
	property p_pulse;
		(external_pin_request_ff & $past(external_pin_request_ff)) == 4'h0;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
endmodule // ecm_props
bind ecm_irq_front ecm_props ecm_props_i (.clock, .rst_b, .bus_req,
	.cpu_evt, .bus_rdata_ff, .external_pin_request_ff, .psw_ff,
	.psw_push_data_ff, .psw_push_stb_ff);
`default_nettype wire

/* sim/ecm_far_model.sv */
/*
 * Far side model: external pins and the comparator bank.
 * Assumes the bench sets the wanted levels on the clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module ecm_far_model
	import ecm_pkg::*;
(
	input wire logic clock,
	input wire logic [N_PIN-1:0] pin_lvl,
	input wire logic [N_CMP-1:0] cmp_lvl,
	output var logic [N_PIN-1:0] ext_pin,
	output var logic [N_CMP-1:0] cmp_detect
);
	initial {ext_pin, cmp_detect} = '0;
	// Pins are asynchronous, so changes land well away from the edge.
	// The pins stay inputs throughout, so no direction change fakes an edge.
	always @(posedge clock) begin
		ext_pin <= #1.3 pin_lvl;
		cmp_detect <= #1.3 cmp_lvl;
	end
endmodule // ecm_far_model
`default_nettype wire

/* sim/ext_comparator_irq_edge_mask_test.sv */
/*
 * Self-checking bench for ecm_irq_front with queues of expectations.
 * Assumes the far model and the checker are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
module ext_comparator_irq_edge_mask_test;
	import ecm_pkg::*;
	logic clock = 1'b0, rst_b = 1'b0, rd_seen = 1'b0, e, tra, trb, pstb;
	logic [3:0] pin_lvl = '0, pe, mon, prq;
	logic [5:0] cmp_lvl = '0, inv = '0, rv, ce, crq;
	logic [7:0] mk, r, rdata, cpu_status_word, pdata, rd_q[$], pu_q[$];
	logic [11:0] x, ev_q[$];
	logic [1:0] p;
	logic [31:0] lfsr = 32'hBC5F;
	ecm_bus_req_t bus_req = '0;
	ecm_cpu_evt_t cpu_evt = '0;
	wire logic [3:0] ext_pin;
	wire logic [5:0] cmp_detect;
	int fail_count = 0, n_tests = 0, cyc = 0;
	localparam logic [19:0] RA [8] = '{ADDR_PIN_RISE, ADDR_PIN_FALL,
		ADDR_CMP_RISE, ADDR_CMP_FALL, ADDR_MONITOR, ADDR_MASK, ADDR_PSW,
		20'hF0500};
	localparam logic [7:0] RV [8] = '{RST_ZERO, RST_ZERO, RST_ZERO,
		RST_ZERO, RST_ZERO, RST_MASK, RST_PSW, RST_ZERO};
	always #2.5 clock = ~clock;
	ecm_far_model ecm_far_model_i (.clock(clock), .pin_lvl(pin_lvl),
		.cmp_lvl(cmp_lvl), .ext_pin(ext_pin), .cmp_detect(cmp_detect));
	ecm_irq_front ecm_irq_front_i (.clock(clock), .rst_b(rst_b),
		.ext_pin(ext_pin), .cmp_detect(cmp_detect),
		.comparator_invert_select(inv), .bus_req(bus_req),
		.cpu_evt(cpu_evt), .bus_rdata_ff(rdata),
		.external_pin_request_ff(prq), .comparator_detect_request_ff(crq),
		.timer_restart_a_ff(tra), .timer_restart_b_ff(trb), .psw_ff(cpu_status_word),
		.psw_push_data_ff(pdata), .psw_push_stb_ff(pstb));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	function automatic logic [31:0] lf(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [11:0] w, y);
		n_tests++;
		if (w !== y) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, w, y);
		end
	endtask
	task automatic close_out();
		if (rd_q.size() + ev_q.size() + pu_q.size() != 0) fail_count++;
		if (fail_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic acc(input logic w, b, input logic [19:0] a,
		input logic [2:0] i, input logic [7:0] d);
		bus_req <= '{1'b1, w, b, a, i, d[0], d};
		@(posedge clock);
		bus_req.valid <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [19:0] a, input logic [7:0] w);
		rd_q.push_back(w);
		acc(1'b0, 1'b0, a, 3'h0, 8'h00);
	endtask
	task automatic ev(input ecm_cpu_evt_t v);
		cpu_evt <= v;
		@(posedge clock);
		cpu_evt <= '0;
		@(posedge clock);
	endtask
	always @(posedge clock) begin
		rd_seen <= bus_req.valid && !bus_req.write;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			close_out();
		end
	end
	// Results are judged half a cycle after the edge, once settled.
	always @(negedge clock) begin
		if (rd_seen)
			chk("read data", {4'h0, rd_q.pop_front()}, {4'h0, rdata});
		if (|{trb, tra, crq, prq})
			chk("request", ev_q.pop_front(), {trb, tra, crq, prq});
		if (pstb)
			chk("push data", {4'h0, pu_q.pop_front()},
				{4'h0, pdata});
	end
	initial begin
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 8; i++) rd(RA[i], RV[i]);
		lfsr = lf(lfsr);
		inv <= lfsr[5:0] ^ 6'h15;
		for (int m = 0; m < 16; m++) begin
			lfsr = lf(lfsr);
			mk = lfsr[7:0];
			p = m[3:2];
			acc(1, 0, ADDR_PIN_RISE, 0, {4'h0, {4{m[1]}}});
			acc(1, 0, ADDR_PIN_FALL, 0, {4'h0, {4{m[0]}}});
			acc(1, 0, ADDR_CMP_RISE, 0, {8{m[1]}});
			acc(1, 0, ADDR_CMP_FALL, 0, {8{m[0]}});
			acc(1, 0, ADDR_MASK, 0, mk);
			rd(ADDR_MASK, mk | 8'h80);
			for (int i = 0; i < 4; i++) acc(1, 1, ADDR_MONITOR, i, 0);
			mon = '0;
			for (int u = 1; u >= 0; u--) begin
				e = u ? m[1] : m[0];
				rv = u ? ~inv : inv;
				ce = (rv & {6{m[1]}} | ~rv & {6{m[0]}}) & {~mk[6:4], 3'h7};
				pe = (e && !mon[p] && !mk[p]) ? 4'h1 << p : 4'h0;
				x = {e & (p == 2'h1), e & (p == 2'h0), ce, pe};
				if (x != 0) ev_q.push_back(x);
				mon[p] = mon[p] | e;
				pin_lvl[p] <= u[0];
				cmp_lvl <= {6{u[0]}};
				repeat (8) @(posedge clock);
			end
			acc(1, 0, ADDR_MONITOR, 0, 8'h00);
			rd(ADDR_MONITOR, {4'h0, mon});
		end
		lfsr = lf(lfsr);
		r = lfsr[7:0];
		ev('{0, 0, 0, 1, 0, 0, 0, 0});
		rd(ADDR_PSW, 8'h86);
		pu_q.push_back(8'h86);
		ev('{1, 2'h2, 0, 0, 0, 0, 0, 0});
		rd(ADDR_PSW, 8'h02);
		ev('{1, 2'h3, 0, 0, 0, 0, 0, 0});
		pu_q.push_back(8'h02);
		pu_q.push_back(8'h02);
		ev('{0, 0, 1, 0, 0, 0, 0, 0});
		ev('{0, 0, 0, 0, 0, 1, 0, 0});
		rd(ADDR_PSW, 8'h02);
		ev('{0, 0, 0, 0, 0, 0, 1, r});
		ev('{0, 0, 0, 0, 1, 0, 0, 0});
		rd(ADDR_PSW, r & 8'h7F);
		acc(1, 1, ADDR_PSW, 7, 1);
		rd(ADDR_PSW, r | 8'h80);
		repeat (4) @(posedge clock);
		chk("status word", {4'h0, r | 8'h80}, {4'h0, cpu_status_word});
		close_out();
	end
endmodule // ext_comparator_irq_edge_mask_test
`default_nettype wire
